/* File: rtl/mcb_top.sv */
/*
  mcb_top: machine-check error banks with global control and model-specific
  register access port.
  assumes: one register access per cycle; read data is registered one cycle
  after the request; error reports come from internal units synchronously.
*/
// Operation
// - capabilities read-only; low eight bits give the number of banks
// - capabilities bit 8 reads one when global enable register exists
// - capabilities bits 9-63 reserved; writes to it have undefined effect
// - global state bit 0: restart at saved pointer is reliable
// - global state bit 1: saved pointer is the faulting instruction
// - global state bit 2 set on exception; software may write it
// - second event while in progress enters shutdown instead of exception
// - global enable all ones enables, all zeros disables the exception and shutdown
// - five banks of control, status, address, misc; bank zero at 400H
// - bank control has 64 enable bits gating each error report
// - only all-ones or all-zeros accepted in bank control
// - status cleared by zero write; nonzero write raises protection fault
// - status holds architectural, model-specific and extra info fields
// - status bit 57 flags possibly corrupted processor context
// - bit 58 flags valid fault address, bit 59 valid extra info
// - status bit 60 set when error was allowed by its enable bit
// - status bit 61 set when the error was not corrected
// - bit 62 set on new error while record valid; software clears
// - enabled replaces disabled, uncorrected replaces corrected, not uncorrected
// - bit 63 marks the record valid; only software or reset clears it
// - address register holds up to 36 bits; upper bits read zero
// - a detected error writes its code into its bank and marks it valid when it replaces the record held there
module mcb_top
  import mcb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // register port
  input wire mcb_req_t req,
  output mcb_rsp_t rsp,
  // error reports, one per bank
  input wire mcb_err_t errIn [NUM_BANKS],
  input wire logic restartOk,
  input wire logic pointerLinked,
  // exception outputs
  output logic machineCheckException,
  output logic shutdown
);

  logic [63:0] enables [NUM_BANKS];
  logic [63:0] record [NUM_BANKS];
  logic [63:0] faultAddr [NUM_BANKS];
  logic [NUM_BANKS-1:0] logged;
  logic [NUM_BANKS-1:0] ctlWr;
  logic [NUM_BANKS-1:0] statusWr;
  logic [2:0] gstate;
  logic [63:0] genable;
  logic [63:0] capValue;
  logic stateWr;
  logic enableWr;
  mcb_rsp_t next_rsp;

  // ----------------------------------------------------------------
  // capabilities value
  // ----------------------------------------------------------------
  always_comb begin
    capValue = ALL_ZEROS;
    capValue[CAP_COUNT_LSB +: CAP_COUNT_W] = 8'(NUM_BANKS);
    capValue[CAP_GEN_EXISTS_BIT] = GLOBAL_ENABLE_PRESENT;
  end

  // ----------------------------------------------------------------
  // banks
  // ----------------------------------------------------------------
  generate
    for (genvar b = 0; b < NUM_BANKS; b++) begin : gBank
      localparam logic [11:0] BASE = BANK0_ADDR + 12'(b) * BANK_STRIDE;
      assign ctlWr[b] = req.wr && req.idx == BASE + 12'(SUB_CTL);
      assign statusWr[b] = req.wr && req.idx == BASE + 12'(SUB_STATUS);
      mcb_bank uBank (
        .clk(clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .ctlWr(ctlWr[b]),
        .statusWr(statusWr[b]),
        .wdata(req.wdata),
        .err(errIn[b]),
        .enables(enables[b]),
        .record(record[b]),
        .faultAddr(faultAddr[b]),
        .loggedEnabled(logged[b])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // global registers
  // ----------------------------------------------------------------
  assign stateWr = req.wr && req.idx == GSTATE_ADDR;
  assign enableWr = req.wr && req.idx == GENABLE_ADDR;

  mcb_global uGlobal (
    .clk(clk),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .stateWr(stateWr),
    .enableWr(enableWr),
    .wdata(req.wdata),
    .anyLogged(|logged),
    .restartOk(restartOk),
    .pointerLinked(pointerLinked),
    .gstate(gstate),
    .genable(genable),
    .exceptionPulse(machineCheckException),
    .shutdown(shutdown)
  );

  // ----------------------------------------------------------------
  // read mux and fault answer
  // ----------------------------------------------------------------
  always_comb begin
    next_rsp.rdata = ALL_ZEROS;
    next_rsp.gpFault = 1'b0;
    if (req.idx == CAP_ADDR) begin
      next_rsp.rdata = capValue;
    end else if (req.idx == GSTATE_ADDR) begin
      next_rsp.rdata = {61'h0, gstate};
    end else if (req.idx == GENABLE_ADDR) begin
      next_rsp.rdata = genable;
    end
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (req.idx == BANK0_ADDR + 12'(b) * BANK_STRIDE + 12'(SUB_CTL)) begin
        next_rsp.rdata = enables[b];
      end else if (req.idx == BANK0_ADDR + 12'(b) * BANK_STRIDE + 12'(SUB_STATUS)) begin
        next_rsp.rdata = record[b];
        if (req.wr && req.wdata != ALL_ZEROS) begin
          next_rsp.gpFault = 1'b1;
        end
      end else if (req.idx == BANK0_ADDR + 12'(b) * BANK_STRIDE + 12'(SUB_ADDR)) begin
        next_rsp.rdata = faultAddr[b];
      end else if (req.idx == BANK0_ADDR + 12'(b) * BANK_STRIDE + 12'(SUB_MISC)) begin
        next_rsp.rdata = ALL_ZEROS;
      end
    end
    if (!req.rd) begin
      next_rsp.rdata = ALL_ZEROS;
    end
    if (!req.wr) begin
      next_rsp.gpFault = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp <= '0;
    end else if (clkEn) begin
      rsp <= next_rsp;
    end
  end

endmodule : mcb_top

/* File: rtl/mcb_pkg.sv */
/*
  mcb_pkg: register indices, field positions, reset values and carrier types
  for the machine-check error banks.
  assumes: registers are reached by a model-specific register read/write port
  with 64-bit data and a register index.
*/
package mcb_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int NUM_BANKS = 5;
  localparam logic [11:0] CAP_ADDR = 12'h179;
  localparam logic [11:0] GSTATE_ADDR = 12'h17a;
  localparam logic [11:0] GENABLE_ADDR = 12'h17b;
  localparam logic [11:0] BANK0_ADDR = 12'h400;
  localparam logic [11:0] BANK_STRIDE = 12'h004;
  localparam logic [1:0] SUB_CTL = 2'h0;
  localparam logic [1:0] SUB_STATUS = 2'h1;
  localparam logic [1:0] SUB_ADDR = 2'h2;
  localparam logic [1:0] SUB_MISC = 2'h3;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int CAP_COUNT_LSB = 0;
  localparam int CAP_COUNT_W = 8;
  localparam int CAP_GEN_EXISTS_BIT = 8;
  localparam logic GLOBAL_ENABLE_PRESENT = 1'b1;
  localparam int GS_RESTART_BIT = 0;
  localparam int GS_LINKED_BIT = 1;
  localparam int GS_INPROG_BIT = 2;
  localparam int ST_ARCH_LSB = 0;
  localparam int ST_MODEL_LSB = 16;
  localparam int ST_OTHER_LSB = 32;
  localparam int ST_CORRUPT_BIT = 57;
  localparam int ST_ADDRESS_CAPTURE_OK_BIT = 58;
  localparam int ST_EXTRA_INFO_OK_BIT = 59;
  localparam int ST_EN_BIT = 60;
  localparam int ST_UNCORR_BIT = 61;
  localparam int ST_OVER_BIT = 62;
  localparam int ST_LIVE_BIT = 63;
  localparam int ADDR_W = 36;
  localparam int ERR_SEL_W = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [63:0] ALL_ONES = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] ALL_ZEROS = 64'h0000_0000_0000_0000;
  localparam logic [63:0] CTL_RESET = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [ERR_SEL_W-1:0] errSel;
    logic [15:0] archCode;
    logic [15:0] modelCode;
    logic [24:0] otherInfo;
    logic uncorrected;
    logic contextCorrupt;
    logic addrValid;
    logic [ADDR_W-1:0] addr;
  } mcb_err_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] idx;
    logic [63:0] wdata;
  } mcb_req_t;

  typedef struct packed {
    logic [63:0] rdata;
    logic gpFault;
  } mcb_rsp_t;

endpackage : mcb_pkg

/* File: rtl/mcb_bank.sv */
/*
  mcb_bank: one error-reporting bank (enables, record, fault address).
  assumes: accesses are decoded by the parent; one error report per cycle.
*/
module mcb_bank
  import mcb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // register access
  input wire logic ctlWr,
  input wire logic statusWr,
  input wire logic [63:0] wdata,
  // error report
  input wire mcb_err_t err,
  // state
  output logic [63:0] enables,
  output logic [63:0] record,
  output logic [63:0] faultAddr,
  output logic loggedEnabled
);

  logic [63:0] next_enables;
  logic [63:0] next_record;
  logic [63:0] next_faultAddr;
  logic allowed;
  logic replace;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_enables = enables;
    next_record = record;
    next_faultAddr = faultAddr;
    allowed = enables[err.errSel];
    replace = 1'b0;
    if (ctlWr && (wdata == ALL_ONES || wdata == ALL_ZEROS)) begin
      next_enables = wdata;
    end
    if (statusWr && wdata == ALL_ZEROS) begin
      next_record = ALL_ZEROS;
    end
    if (err.valid) begin
      if (!next_record[ST_LIVE_BIT]) begin
        replace = 1'b1;
      end else if (next_record[ST_UNCORR_BIT]) begin
        replace = 1'b0;
      end else if (allowed && !next_record[ST_EN_BIT]) begin
        replace = 1'b1;
      end else if (err.uncorrected) begin
        replace = 1'b1;
      end
      if (record[ST_LIVE_BIT] && !statusWr) begin
        next_record[ST_OVER_BIT] = 1'b1;
      end
      if (replace) begin
        next_record[ST_ARCH_LSB +: 16] = err.archCode;
        next_record[ST_MODEL_LSB +: 16] = err.modelCode;
        next_record[ST_OTHER_LSB +: 25] = err.otherInfo;
        next_record[ST_CORRUPT_BIT] = err.contextCorrupt;
        next_record[ST_ADDRESS_CAPTURE_OK_BIT] = err.addrValid;
        next_record[ST_EXTRA_INFO_OK_BIT] = 1'b0;
        next_record[ST_EN_BIT] = allowed;
        next_record[ST_UNCORR_BIT] = err.uncorrected;
        next_record[ST_LIVE_BIT] = 1'b1;
        if (err.addrValid) begin
          next_faultAddr = {28'h000_0000, err.addr};
        end
      end
    end
    loggedEnabled = err.valid && replace && allowed;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enables <= CTL_RESET;
      record <= ALL_ZEROS;
      faultAddr <= ALL_ZEROS;
    end else if (clkEn) begin
      enables <= next_enables;
      record <= next_record;
      faultAddr <= next_faultAddr;
    end
  end

endmodule : mcb_bank

/* File: rtl/mcb_global.sv */
/*
  mcb_global: global state and global enable registers, exception and
  shutdown decision.
  assumes: a logged enabled error is flagged by the banks for the one cycle in which it is logged.
*/
module mcb_global
  import mcb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // register access
  input wire logic stateWr,
  input wire logic enableWr,
  input wire logic [63:0] wdata,
  // event
  input wire logic anyLogged,
  input wire logic restartOk,
  input wire logic pointerLinked,
  // outputs
  output logic [2:0] gstate,
  output logic [63:0] genable,
  output logic exceptionPulse,
  output logic shutdown
);

  logic [2:0] next_gstate;
  logic [63:0] next_genable;
  logic next_exceptionPulse;
  logic next_shutdown;
  logic fire;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_gstate = gstate;
    next_genable = genable;
    next_shutdown = shutdown;
    if (enableWr && GLOBAL_ENABLE_PRESENT) begin
      next_genable = wdata;
    end
    if (stateWr) begin
      next_gstate = wdata[2:0];
    end
    fire = anyLogged && (genable == ALL_ONES);
    next_exceptionPulse = 1'b0;
    if (fire) begin
      if (gstate[GS_INPROG_BIT]) begin
        next_shutdown = 1'b1;
      end else begin
        next_exceptionPulse = 1'b1;
        next_gstate[GS_INPROG_BIT] = 1'b1;
        next_gstate[GS_RESTART_BIT] = restartOk;
        next_gstate[GS_LINKED_BIT] = pointerLinked;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gstate <= 3'h0;
      genable <= ALL_ZEROS;
      exceptionPulse <= 1'b0;
      shutdown <= 1'b0;
    end else if (clkEn) begin
      gstate <= next_gstate;
      genable <= next_genable;
      exceptionPulse <= next_exceptionPulse;
      shutdown <= next_shutdown;
    end
  end

endmodule : mcb_global

/* File: sim/mcb_checker.sv */
/*
  mcb_checker: concurrent checks on the ports of mcb_top.
  assumes: bound into mcb_top; one clock domain, reset rst_b active low.
*/
module mcb_checker
  import mcb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // register port
  input wire mcb_req_t req,
  input wire mcb_rsp_t rsp,
  // error reports
  input wire mcb_err_t errIn [NUM_BANKS],
  input wire logic restartOk,
  input wire logic pointerLinked,
  // exception outputs
  input wire logic machineCheckException,
  input wire logic shutdown
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rdOk;
  logic statWr;
  logic anyErr;
  assign rdOk = clkEn && req.rd;
  assign statWr = clkEn && req.wr && req.wdata != 64'h0 &&
    req.idx inside {12'h401, 12'h405, 12'h409, 12'h40d, 12'h411};
  assign anyErr = errIn[0].valid | errIn[1].valid | errIn[2].valid | errIn[3].valid | errIn[4].valid;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  sequence capRead;
    rdOk && !req.wr && req.idx == CAP_ADDR;
  endsequence
  chk_cap_value: assert property (capRead |=> rsp.rdata == 64'h105)
    else $error("capabilities value wrong");
  chk_cap_reserved: assert property (capRead |=> rsp.rdata[63:9] == 55'h0)
    else $error("capabilities reserved bits not zero");
  chk_misc_zero: assert property (rdOk && req.idx inside {12'h403, 12'h407, 12'h40b, 12'h40f, 12'h413}
    |=> rsp.rdata == 64'h0) else $error("misc register not zero");
  chk_addr_upper: assert property (rdOk && req.idx inside {12'h402, 12'h406, 12'h40a, 12'h40e, 12'h412}
    |=> rsp.rdata[63:36] == 28'h0) else $error("address upper bits not zero");
  chk_gp_fault: assert property (clkEn |=> rsp.gpFault == $past(statWr))
    else $error("protection fault mismatch");
  chk_exc_cause: assert property (machineCheckException |-> $past(anyErr))
    else $error("exception without error");
  chk_exc_pulse: assert property (machineCheckException && clkEn |=> !machineCheckException)
    else $error("exception longer than one cycle");
  chk_shut_sticky: assert property (shutdown |=> shutdown)
    else $error("shutdown dropped");
  chk_shut_cause: assert property ($rose(shutdown) |-> $past(anyErr))
    else $error("shutdown without error");
endmodule : mcb_checker

bind mcb_top mcb_checker chk (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .req(req), .rsp(rsp),
  .errIn(errIn), .restartOk(restartOk), .pointerLinked(pointerLinked),
  .machineCheckException(machineCheckException), .shutdown(shutdown));

/* File: sim/tb_top.sv */
/*
  tb_top: directed bench for the machine-check error banks.
  assumes: mcb_top with its checker bound; clkEn held high except low around one global enable write.
*/
module tb_top
  import mcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_b, clkEn, restartOk, pointerLinked, machineCheckException, shutdown;
  mcb_req_t req;
  mcb_rsp_t rsp, r;
  mcb_err_t errIn [NUM_BANKS];
  mcb_err_t ea, eb, ec, ed;
  int fails, nChecks, nExc;

  mcb_top dut (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .req(req), .rsp(rsp), .errIn(errIn),
    .restartOk(restartOk), .pointerLinked(pointerLinked),
    .machineCheckException(machineCheckException), .shutdown(shutdown));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (machineCheckException === 1'b1) nExc++;
  end
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task chk(input logic [63:0] got, input logic [63:0] exp);
    nChecks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task acc(input logic w, input logic [11:0] i, input logic [63:0] d);
    @(posedge clk);
    req <= '{rd: !w, wr: w, idx: i, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
    r = rsp;
  endtask : acc

  task wr(input logic [11:0] i, input logic [63:0] d);
    acc(1'b1, i, d);
  endtask : wr

  task rd(input logic [11:0] i, input logic [63:0] exp);
    acc(1'b0, i, 64'h0);
    chk(r.rdata, exp);
  endtask : rd

  task raise(input int b, input mcb_err_t e);
    @(posedge clk);
    errIn[b] <= e;
    @(posedge clk);
    errIn[b] <= '0;
    @(posedge clk);
  endtask : raise

  function automatic mcb_err_t mk(input logic u, input logic [15:0] a);
    mk = '{valid: 1'b1, errSel: a[5:0], archCode: a, modelCode: ~a, otherInfo: {9'h0, a},
      uncorrected: u, contextCorrupt: u, addrValid: 1'b1, addr: {a, a, 4'h9}};
  endfunction : mk

  function automatic logic [63:0] st(input mcb_err_t e, input logic en, input logic ov);
    st = {1'b1, ov, e.uncorrected, en, 1'b0, e.addrValid, e.contextCorrupt, e.otherInfo,
      e.modelCode, e.archCode};
  endfunction : st

  task conclude;
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  // ------------------------------------------------
  // tests
  // ------------------------------------------------
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    conclude();
  end

  initial begin
    rst_b = 1'b0;
    clkEn = 1'b1;
    restartOk = 1'b1;
    pointerLinked = 1'b0;
    req = '0;
    foreach (errIn[b]) errIn[b] = '0;
    ea = mk(1'b0, 16'h0001);
    eb = mk(1'b0, 16'h0412);
    ec = mk(1'b1, 16'h0113);
    ed = mk(1'b1, 16'h0004);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(CAP_ADDR, 64'h105);
    rd(CAP_ADDR, 64'h105);
    rd(GSTATE_ADDR, 64'h0);
    wr(12'h404, 64'h1234);
    rd(12'h404, 64'h0);
    rd(BANK0_ADDR, 64'h0);
    rd(BANK0_ADDR + 12'(3), 64'h0);
    for (int b = 1; b < NUM_BANKS; b++) begin
      wr(BANK0_ADDR + 12'(4 * b), ALL_ONES);
      rd(BANK0_ADDR + 12'(4 * b), ALL_ONES);
      rd(BANK0_ADDR + 12'(4 * b + 3), 64'h0);
    end
    wr(12'h408, ALL_ZEROS);
    rd(12'h408, ALL_ZEROS);
    raise(1, ea);
    rd(12'h405, st(ea, 1'b1, 1'b0));
    rd(12'h406, {28'h0, ea.addr});
    chk(nExc, 0);
    wr(12'h405, ALL_ONES);
    chk(r.gpFault, 1);
    rd(12'h405, st(ea, 1'b1, 1'b0));
    wr(12'h405, ALL_ZEROS);
    chk(r.gpFault, 0);
    rd(12'h405, 64'h0);
    raise(0, eb);
    rd(12'h401, st(eb, 1'b0, 1'b0));
    raise(2, ea);
    rd(12'h409, st(ea, 1'b0, 1'b0));
    wr(12'h408, ALL_ONES);
    raise(2, eb);
    rd(12'h409, st(eb, 1'b1, 1'b1));
    raise(2, ec);
    rd(12'h409, st(ec, 1'b1, 1'b1));
    raise(2, ed);
    rd(12'h409, st(ec, 1'b1, 1'b1));
    wr(GENABLE_ADDR, ALL_ONES);
    rd(GENABLE_ADDR, ALL_ONES);
    @(posedge clk);
    clkEn <= 1'b0;
    wr(GENABLE_ADDR, ALL_ZEROS);
    @(posedge clk);
    clkEn <= 1'b1;
    rd(GENABLE_ADDR, ALL_ONES);
    raise(3, ec);
    rd(GSTATE_ADDR, 64'h5);
    chk(nExc, 1);
    wr(GSTATE_ADDR, 64'h0);
    rd(GSTATE_ADDR, 64'h0);
    @(posedge clk);
    restartOk <= 1'b0;
    pointerLinked <= 1'b1;
    raise(4, ed);
    rd(GSTATE_ADDR, 64'h6);
    chk(nExc, 2);
    raise(1, ec);
    rd(12'h405, st(ec, 1'b1, 1'b0));
    chk({63'h0, shutdown}, 1);
    chk(nExc, 2);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(12'h405, 64'h0);
    rd(GSTATE_ADDR, 64'h0);
    chk({63'h0, shutdown}, 0);
    conclude();
  end
endmodule : tb_top
